// File: cbpes_pkg.sv
/*
 package for the performance event selector: event codes, qualifiers,
 bus throttle limits and the carrier structs.
 assumes a single core clock and synchronous use everywhere.
*/
package cbpes_pkg;

   localparam logic [7:0] EV_SPLIT       = 8'h49;
   localparam logic [7:0] EV_SWPF_MISS   = 8'h4b;
   localparam logic [7:0] EV_LOAD_HIT_PF = 8'h4c;
   localparam logic [7:0] EV_L1D_PF_REQ  = 8'h4e;
   localparam logic [7:0] EV_BUS_OUTST   = 8'h60;
   localparam logic [7:0] EV_BUS_THROT   = 8'h61;

   localparam logic [7:0] QUAL_SPLIT_ST  = 8'h02;
   localparam logic [7:0] QUAL_NONTEMP   = 8'h00;
   localparam logic [7:0] QUAL_ALL_LVL   = 8'h01;
   localparam logic [7:0] QUAL_OUTER     = 8'h02;
   localparam logic [7:0] QUAL_LOAD_HIT  = 8'h00;
   localparam logic [7:0] QUAL_PF_REQ    = 8'h10;

   // pending-read tracker size and throttle thresholds
   localparam int         OUTST_W        = 4;
   localparam logic [3:0] OUTST_MAX      = 4'h8;
   localparam int         TXN_W          = 5;
   localparam logic [4:0] TXN_LIMIT      = 5'h10;
   localparam logic [4:0] TXN_NEAR       = 5'h0e;
   // bus-not-ready is driven for this many bus cycles per assertion
   localparam logic [1:0] THROT_CYCLES   = 2'h2;

   localparam logic [OUTST_W-1:0] OUTST_RST = 4'h0;
   localparam logic [TXN_W-1:0]   TXN_RST   = 5'h00;

   typedef enum logic [2:0] {
      CBPES_RD_L1D,
      CBPES_RD_L2PF,
      CBPES_RD_RFO,
      CBPES_RD_IFETCH,
      CBPES_RD_OTHER
   } cbpes_src_t;

   // execution-side events, one-cycle pulses
   typedef struct packed {
      logic split_store;
      logic pf_nontemporal_miss;
      logic pf_all_levels_miss;
      logic pf_level_two_miss;
      logic pf_level_three_miss;
      logic load_to_l1d;
      logic load_hits_pending_pf;
      logic l1d_pf_request;
   } cbpes_core_ev_t;

   // bus-side events
   typedef struct packed {
      logic       read_issue;
      logic       read_full_line;
      logic       read_cacheable;
      cbpes_src_t read_src;
      logic       read_line_done;
      logic       txn_start;
      logic       txn_end;
   } cbpes_bus_ev_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] qual;
   } cbpes_sel_t;

endpackage : cbpes_pkg

// File: cbpes_throttle.sv
/*
 bus-not-ready driver: tracks data and snoop transactions in flight and
 asserts the throttle for two bus cycles as the count nears the bus limit.
 assumes txn_start/txn_end pulses are synchronous to clk_sys.
*/
`timescale 1ns/1ns
module cbpes_throttle (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic txn_start,
   input  wire logic txn_end,
   output logic      bus_not_ready,
   output logic      assert_pulse
);

   logic [cbpes_pkg::TXN_W-1:0] txn_cnt_q;
   logic [cbpes_pkg::TXN_W-1:0] txn_cnt_d;
   logic [1:0]                  hold_q;
   logic [1:0]                  hold_d;
   logic                        near_full;
   logic                        start_assert;

   assign txn_cnt_d = (txn_start && !txn_end && txn_cnt_q != cbpes_pkg::TXN_LIMIT) ? txn_cnt_q + 5'h01 :
                      (txn_end && !txn_start && txn_cnt_q != cbpes_pkg::TXN_RST)   ? txn_cnt_q - 5'h01 :
                      txn_cnt_q;
   assign near_full    = txn_cnt_q >= cbpes_pkg::TXN_NEAR; // RQ12
   // a fresh assertion only once the previous two-cycle pulse has ended
   assign start_assert = near_full && hold_q == 2'h0; // RQ13
   assign hold_d       = start_assert ? cbpes_pkg::THROT_CYCLES :
                         (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txn_cnt_q     <= cbpes_pkg::TXN_RST;
         hold_q        <= 2'h0;
         bus_not_ready <= 1'b0;
         assert_pulse  <= 1'b0;
      end else begin
         txn_cnt_q     <= txn_cnt_d;
         hold_q        <= hold_d;
         bus_not_ready <= hold_d != 2'h0; // RQ13
         assert_pulse  <= start_assert; // RQ11
      end
   end

endmodule : cbpes_throttle

// File: cbpes_top.sv
/*
 event selection for the performance counters: decodes the programmed
 event code and qualifier, detects the chosen condition and presents an
 increment amount to the counter each cycle.
 assumes the counter adds inc_amount every cycle and that event inputs
 are single-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/1ns
// Overview of operation
// [RQ1] code 49h qualifier 02h counts stores that cross a cache line boundary
// [RQ2] code 4bh qualifier 00h counts non-temporal software prefetches missing all levels
// [RQ3] code 4bh qualifier 01h counts all-levels-hint prefetches missing all levels
// [RQ4] code 4bh qualifier 02h counts level-two and level-three hint misses together
// [RQ5] prefetch misses counted at execution, including speculative ones never retired
// [RQ6] code 4ch qualifier 00h counts loads hitting an unfinished software prefetch line
// [RQ7] code 4eh qualifier 10h counts every first-level data prefetch request, rejected too
// [RQ8] first-level prefetch requests may be rejected while the second-level cache is busy
// [RQ9] code 60h adds pending full-line reads every cycle, issue until line arrives
// [RQ10] outstanding reads: only cacheable full-line reads from data cache or prefetchers
// [RQ11] code 61h counts each bus-not-ready assertion this device drives
// [RQ12] bus-not-ready asserts when data and snoop transactions near the bus maximum
// [RQ13] each counted assertion lasts two bus cycles
// [RQ14] no new transaction is issued while bus-not-ready is asserted
// [RQ15] an event counts only when both code and qualifier match; codes 60h and 61h ignore the qualifier
module cbpes_top (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire cbpes_pkg::cbpes_sel_t     sel,
   input  wire cbpes_pkg::cbpes_core_ev_t core_ev,
   input  wire cbpes_pkg::cbpes_bus_ev_t  bus_ev,
   input  wire logic                      l2_busy,
   input  wire logic                      pf_req_resubmit,
   input  wire logic                      issue_req,
   output logic [cbpes_pkg::OUTST_W-1:0]  inc_amount_q,
   output logic                           bus_not_ready_q,
   output logic                           issue_grant_q,
   output logic                           pf_req_accept_q,
   output logic                           pf_req_dropped_q
);

   logic [cbpes_pkg::OUTST_W-1:0] outst_q;
   logic [cbpes_pkg::OUTST_W-1:0] outst_d;
   logic [cbpes_pkg::OUTST_W-1:0] inc_d;
   logic                          throt_level;
   logic                          throt_start;

   // selection decode
   wire code_split   = sel.code == cbpes_pkg::EV_SPLIT;
   wire code_swpf    = sel.code == cbpes_pkg::EV_SWPF_MISS;
   wire code_ldhit   = sel.code == cbpes_pkg::EV_LOAD_HIT_PF;
   wire code_pfreq   = sel.code == cbpes_pkg::EV_L1D_PF_REQ;
   wire code_outst   = sel.code == cbpes_pkg::EV_BUS_OUTST;
   wire code_throt   = sel.code == cbpes_pkg::EV_BUS_THROT;

   wire sel_split_store   = code_split && sel.qual == cbpes_pkg::QUAL_SPLIT_ST; // RQ15
   wire sel_nontemporal   = code_swpf  && sel.qual == cbpes_pkg::QUAL_NONTEMP;  // RQ15
   wire sel_all_level     = code_swpf  && sel.qual == cbpes_pkg::QUAL_ALL_LVL;  // RQ15
   wire sel_outer_level   = code_swpf  && sel.qual == cbpes_pkg::QUAL_OUTER;    // RQ15
   wire sel_load_hit      = code_ldhit && sel.qual == cbpes_pkg::QUAL_LOAD_HIT; // RQ15
   wire sel_pf_requests   = code_pfreq && sel.qual == cbpes_pkg::QUAL_PF_REQ;   // RQ15

   // detected conditions
   wire split_line_store_count        = core_ev.split_store; // RQ1
   // misses are taken at execution, so squashed prefetches still count
   wire nontemporal_prefetch_miss     = core_ev.pf_nontemporal_miss; // RQ5
   wire all_level_prefetch_miss       = core_ev.pf_all_levels_miss; // RQ5
   wire outer_level_prefetch_miss     = core_ev.pf_level_two_miss
                                        || core_ev.pf_level_three_miss; // RQ4
   wire load_hit_pending_prefetch     = core_ev.load_to_l1d && core_ev.load_hits_pending_pf; // RQ6
   // counted at request time, ahead of any rejection
   wire first_level_prefetch_requests = core_ev.l1d_pf_request; // RQ7

   // a request seen while the second-level cache is busy is rejected
   wire pf_reject = core_ev.l1d_pf_request && l2_busy; // RQ8

   wire read_qualifies = bus_ev.read_full_line && bus_ev.read_cacheable
                         && (bus_ev.read_src == cbpes_pkg::CBPES_RD_L1D
                             || bus_ev.read_src == cbpes_pkg::CBPES_RD_L2PF); // RQ10
   // issue is refused while throttled, so a qualifying read is never counted then
   wire read_start  = bus_ev.read_issue && read_qualifies && !throt_level
                      && outst_q != cbpes_pkg::OUTST_MAX; // RQ14
   wire read_finish = bus_ev.read_line_done && outst_q != cbpes_pkg::OUTST_RST;

   assign outst_d = (read_start && !read_finish) ? outst_q + 4'h1 :
                    (read_finish && !read_start) ? outst_q - 4'h1 :
                    outst_q; // RQ9

   assign inc_d = (sel_split_store && split_line_store_count)      ? 4'h1 : // RQ1
                  (sel_nontemporal && nontemporal_prefetch_miss)   ? 4'h1 : // RQ2
                  (sel_all_level   && all_level_prefetch_miss)     ? 4'h1 : // RQ3
                  (sel_outer_level && outer_level_prefetch_miss)   ?
                     {2'h0, core_ev.pf_level_two_miss && core_ev.pf_level_three_miss,
                      core_ev.pf_level_two_miss ^ core_ev.pf_level_three_miss} : // RQ4
                  (sel_load_hit    && load_hit_pending_prefetch)   ? 4'h1 : // RQ6
                  (sel_pf_requests && first_level_prefetch_requests) ? 4'h1 : // RQ7
                  code_outst                                       ? outst_q : // RQ9
                  (code_throt      && throt_start)                 ? 4'h1 : // RQ11
                  4'h0;

   cbpes_throttle u_throttle (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .txn_start     (bus_ev.txn_start),
      .txn_end       (bus_ev.txn_end),
      .bus_not_ready (throt_level),
      .assert_pulse  (throt_start)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         outst_q          <= cbpes_pkg::OUTST_RST;
         inc_amount_q     <= 4'h0;
         bus_not_ready_q  <= 1'b0;
         issue_grant_q    <= 1'b0;
         pf_req_accept_q  <= 1'b0;
         pf_req_dropped_q <= 1'b0;
      end else begin
         outst_q          <= outst_d;
         inc_amount_q     <= inc_d;
         bus_not_ready_q  <= throt_level; // RQ12
         issue_grant_q    <= issue_req && !throt_level; // RQ14
         pf_req_accept_q  <= core_ev.l1d_pf_request && !l2_busy;
         // rejected and not marked for resubmission means lost
         pf_req_dropped_q <= pf_reject && !pf_req_resubmit; // RQ8
      end
   end

endmodule : cbpes_top

// File: cbpes_top_assertions.sv
/* checker for cbpes_top: selected event amounts, prefetch rejects, throttle.
 sees only the top ports; bound from the testbench top file. */
`timescale 1ns/1ns
module cbpes_top_assertions (
   input wire logic                      clk_sys,
   input wire logic                      rst,
   input wire cbpes_pkg::cbpes_sel_t     sel,
   input wire cbpes_pkg::cbpes_core_ev_t core_ev,
   input wire logic                      l2_busy,
   input wire logic                      pf_req_resubmit,
   input wire logic [3:0]                inc_amount_q,
   input wire logic                      bus_not_ready_q,
   input wire logic                      issue_grant_q,
   input wire logic                      pf_req_dropped_q,
   input wire logic                      pf_req_accept_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic [15:0] s = sel;
   split_store_a: assert property (s == 16'h4902 |=> inc_amount_q == 4'($past(core_ev.split_store)))
      else $error("split store amount wrong");
   nontemporal_miss_a: assert property (s == 16'h4b00 |=> inc_amount_q == 4'($past(core_ev.pf_nontemporal_miss)))
      else $error("nontemporal miss amount wrong");
   all_level_miss_a: assert property (s == 16'h4b01 |=> inc_amount_q == 4'($past(core_ev.pf_all_levels_miss)))
      else $error("all level miss amount wrong");
   outer_miss_a: assert property (s == 16'h4b02 |=> inc_amount_q ==
      4'($past(core_ev.pf_level_two_miss)) + 4'($past(core_ev.pf_level_three_miss))) else $error("outer miss sum wrong");
   load_hit_a: assert property (s == 16'h4c00 && core_ev.load_to_l1d |=>
      inc_amount_q == 4'($past(core_ev.load_hits_pending_pf))) else $error("load hit amount wrong");
   pf_req_a: assert property (s == 16'h4e10 |=> inc_amount_q == 4'($past(core_ev.l1d_pf_request)))
      else $error("prefetch request amount wrong");
   qual_match_a: assert property (sel.code == 8'h4e && sel.qual != 8'h10 |=> inc_amount_q == 4'h0)
      else $error("wrong qualifier still counted");
   pf_reject_a: assert property (core_ev.l1d_pf_request && l2_busy |=> !pf_req_accept_q &&
      pf_req_dropped_q == !$past(pf_req_resubmit)) else $error("rejected prefetch handling wrong");
   throt_len_a: assert property ($rose(bus_not_ready_q) |-> bus_not_ready_q [*2])
      else $error("throttle shorter than two cycles");
   no_issue_a: assert property (bus_not_ready_q |-> !issue_grant_q)
      else $error("grant while throttled");
   cover property ($rose(bus_not_ready_q));
   cover property (s == 16'h6000 && inc_amount_q == 4'h2);
   cover property (pf_req_dropped_q);
endmodule : cbpes_top_assertions

// File: cbpes_top_tb_top.sv
/* testbench for cbpes_top: random events per selection, pending reads, throttle.
 inputs change on the falling edge; the checker is bound below. */
`timescale 1ns/1ns
module cbpes_top_tb_top;
   logic                      clk_sys = 1'b0;
   logic                      rst = 1'b1;
   cbpes_pkg::cbpes_sel_t     sel = '0;
   cbpes_pkg::cbpes_core_ev_t core_ev = '0;
   cbpes_pkg::cbpes_bus_ev_t  bus_ev = '0;
   logic                      l2_busy = 1'b0;
   logic                      pf_req_resubmit = 1'b0;
   logic                      issue_req = 1'b0;
   logic [3:0]                inc_amount_q;
   logic                      bus_not_ready_q, issue_grant_q, pf_req_accept_q, pf_req_dropped_q;
   int                        bad_count = 0;
   int                        checked = 0;
   int                        seed = 32'h9927;
   int                        i, k, hi, sum;
   logic [15:0]               tab [8] = '{16'h4902, 16'h4901, 16'h4b00, 16'h4b01, 16'h4b02, 16'h4c00, 16'h4e10, 16'h4e00};
   cbpes_top dut (.clk_sys(clk_sys), .rst(rst), .sel(sel), .core_ev(core_ev), .bus_ev(bus_ev), .l2_busy(l2_busy),
      .pf_req_resubmit(pf_req_resubmit), .issue_req(issue_req), .inc_amount_q(inc_amount_q),
      .bus_not_ready_q(bus_not_ready_q), .issue_grant_q(issue_grant_q), .pf_req_accept_q(pf_req_accept_q),
      .pf_req_dropped_q(pf_req_dropped_q));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [3:0] exp_inc(input logic [15:0] s, input cbpes_pkg::cbpes_core_ev_t e);
      case (s)
         16'h4902: return 4'(e.split_store);
         16'h4b00: return 4'(e.pf_nontemporal_miss);
         16'h4b01: return 4'(e.pf_all_levels_miss);
         16'h4b02: return 4'(e.pf_level_two_miss) + 4'(e.pf_level_three_miss);
         16'h4c00: return 4'(e.load_to_l1d & e.load_hits_pending_pf);
         16'h4e10: return 4'(e.l1d_pf_request);
         default: return 4'h0;
      endcase
   endfunction : exp_inc
   task automatic wrap_up;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial forever #25 clk_sys = ~clk_sys;
   initial begin
      #100000 bad_count++;
      wrap_up();
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      for (k = 0; k < 8; k++) begin
         sel = tab[k];
         for (i = 0; i < 40; i++) begin
            core_ev = 8'($random(seed));
            core_ev.load_hits_pending_pf &= core_ev.load_to_l1d;
            {l2_busy, pf_req_resubmit, issue_req} = 3'($random(seed));
            @(negedge clk_sys);
            check({4'h0, inc_amount_q}, {4'h0, exp_inc(sel, core_ev)});
            check({5'h0, pf_req_accept_q, pf_req_dropped_q, issue_grant_q}, {5'h0, core_ev.l1d_pf_request &
               !l2_busy, core_ev.l1d_pf_request & l2_busy & !pf_req_resubmit, issue_req});
         end
         $display("events for selection %h done", sel);
      end
      {core_ev, l2_busy, pf_req_resubmit, issue_req} = '0;
      sel = 16'h6000;
      // sources cycle l1d, l2pf, rfo, ifetch, other; then a partial and an uncacheable read
      for (k = 0; k < 7; k++) begin
         bus_ev = '0;
         bus_ev.read_issue = 1'b1;
         bus_ev.read_full_line = (k != 5);
         bus_ev.read_cacheable = (k != 6);
         bus_ev.read_src = cbpes_pkg::cbpes_src_t'(3'(k % 5));
         @(negedge clk_sys);
      end
      for (k = 2; k >= 0; k--) begin
         bus_ev = '0;
         repeat (3) @(negedge clk_sys);
         check({4'h0, inc_amount_q}, 8'(k));
         bus_ev.read_line_done = 1'b1;
         @(negedge clk_sys);
      end
      $display("pending reads done");
      sel = 16'h6100;
      issue_req = 1'b1;
      hi = 0;
      sum = 0;
      for (i = 0; i < 60; i++) begin
         bus_ev = '0;
         bus_ev.txn_start = (i < 14);
         bus_ev.txn_end = (i >= 25 && i < 39);
         @(negedge clk_sys);
         if (i == 12) check({7'h0, bus_not_ready_q}, 8'h0);
         check({7'h0, issue_grant_q}, {7'h0, !bus_not_ready_q});
         hi += bus_not_ready_q;
         sum += inc_amount_q;
      end
      check(8'(hi > 0), 8'h1);
      check(8'(hi), 8'(sum * 2));
      $display("throttle done");
      wrap_up();
   end
endmodule : cbpes_top_tb_top
bind cbpes_top cbpes_top_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .sel(sel), .core_ev(core_ev),
   .l2_busy(l2_busy), .pf_req_resubmit(pf_req_resubmit), .inc_amount_q(inc_amount_q),
   .bus_not_ready_q(bus_not_ready_q), .issue_grant_q(issue_grant_q), .pf_req_dropped_q(pf_req_dropped_q),
   .pf_req_accept_q(pf_req_accept_q));
